// file: lsc_pkg.sv
/*
  Shared constants and types for the load switch fault controller.
  Assumes a 100 MHz reference clock; all timing counts derive from it.
*/
`default_nettype none

package lsc_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  // Reference clock period in nanoseconds.
  localparam int CLK_PERIOD_NS = 10;
  // Typical blanking interval, in microseconds (17.5 ms).
  localparam int BLANK_TIME_US = 17500;
  // Typical retry interval, in milliseconds.
  localparam int RETRY_TIME_MS = 560;
  // Retry interval is this multiple of the blanking interval.
  localparam int RETRY_RATIO = 32;
  // Blanking interval in reference clock cycles (a least time, rounded up).
  localparam int BLANK_CYCLES = (BLANK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Retry interval in cycles, tied to the blanking count by the fixed ratio.
  localparam int RETRY_CYCLES = BLANK_CYCLES * RETRY_RATIO;
  // Width of the shared interval counter; holds the retry count.
  localparam int CNT_W = 26;

  // ----------------------------------------------------------------
  // Synchronised input vector layout
  // ----------------------------------------------------------------
  localparam int SYNC_W = 5;
  localparam int BIT_OVERCURRENT = 0;
  localparam int BIT_REVERSE = 1;
  localparam int BIT_OVERTEMP = 2;
  localparam int BIT_SET_SHORT = 3;
  localparam int BIT_SWITCH_ON = 4;
  // Default reset value of the synchroniser stages; the low-on variant sets its switch-on bit.
  localparam logic [SYNC_W-1:0] SYNC_RESET = 5'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Overcurrent response variant fitted in the device.
  typedef enum logic [1:0] {
    VAR_AUTO_RETRY = 2'h0,
    VAR_AUTO_RETRY_LOW_ON = 2'h1,
    VAR_LATCH_OFF = 2'h2,
    VAR_CONTINUOUS = 2'h3
  } lsc_variant_t;

  // Fault sequencing states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_BLANK = 3'h1,
    ST_REBLANK = 3'h2,
    ST_RETRY = 3'h3,
    ST_LATCHED = 3'h4,
    ST_LIMIT = 3'h5
  } lsc_state_t;

endpackage

`default_nettype wire

// file: lsc_sync_if.sv
/*
  Interface carrying raw asynchronous indications into the synchroniser
  and the synchronised copies back out. Assumes the lsc_pkg package.
*/
`timescale 1ns/10ps
`default_nettype none

interface lsc_sync_if;
  // Raw levels straight from the pins and comparators.
  logic [lsc_pkg::SYNC_W-1:0] raw;
  // Levels after two flip-flops in the reference clock domain.
  logic [lsc_pkg::SYNC_W-1:0] sync;

  // The controller supplies raw levels and reads the synchronised ones.
  modport src (output raw, input sync);
  // The synchroniser reads raw levels and drives the synchronised ones.
  modport dst (input raw, output sync);
endinterface

`default_nettype wire

// file: lsc_sync2.sv
/*
  Two flip-flop synchroniser for the comparator and switch-on levels.
  Assumes one reference clock, an active-low asynchronous reset and a
  clock enable that freezes both stages.
*/
`timescale 1ns/10ps
`default_nettype none

module lsc_sync2 #(
  // Level both stages take in reset; each bit should be its pin's idle level.
  parameter logic [lsc_pkg::SYNC_W-1:0] RESET_VAL = lsc_pkg::SYNC_RESET
) (
  // Clock, reset and enable.
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Raw in, synchronised out.
  lsc_sync_if.dst port
);

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  // First stage; read only by the second stage, since it may be metastable.
  logic [lsc_pkg::SYNC_W-1:0] stage1;

  // Both stages shift together; nothing else looks at stage1.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stage1 <= RESET_VAL;
      port.sync <= RESET_VAL;
    end
    else if (clk_en)
    begin
      stage1 <= port.raw;
      port.sync <= stage1;
    end
  end

endmodule

`default_nettype wire

// file: lsc_fault_ctrl.sv
/*
  Digital fault sequencing for an adjustable current-limit load switch:
  blanking and retry timing, latch-off, continuous limiting, and the
  open-drain fault indicator.
  Assumes comparator levels arrive asynchronously and are clean levels;
  the analog limiting itself lives outside this block.
*/
// What this block does
// - Blanking timer starts on overcurrent, clears early
// - Auto-retry: fault asserts after full blanking
// - Auto-retry: off for retry interval, retry
// - Fault stays asserted through whole retry cycling
// - Blanking 17.5 ms, retry 560 ms typical
// - Retry interval is thirty-two blanking intervals
// - Latch-off: fault, switch off, stays latched
// - Latch clears by switch-on toggle or power
// - Continuous: conduct, flag after blanking, clear
// - Switch-on polarity depends on fitted variant
// - Reverse current: immediate off and fault
// - Fault on blanking, reverse, heat, short
// - Over-temperature: immediate off and fault
// - Grounded limit-set pin asserts fault
// - Grounded limit-set pin forces switch off
`timescale 1ns/10ps
`default_nettype none

module lsc_fault_ctrl #(
  // Fitted overcurrent response and switch-on polarity.
  parameter lsc_pkg::lsc_variant_t VARIANT = lsc_pkg::VAR_AUTO_RETRY,
  // Blanking count; shorten in simulation.
  parameter int BLANK_CYCLES = lsc_pkg::BLANK_CYCLES,
  // Retry count; kept at the fixed ratio by default.
  parameter int RETRY_CYCLES = BLANK_CYCLES * lsc_pkg::RETRY_RATIO
) (
  // Clock, reset and enable.
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // Asynchronous comparator indications, active high.
  input wire logic overcurrent,
  input wire logic reverse_trip,
  input wire logic overtemp,
  input wire logic limit_set_pin_short,
  // Switch-on pin, polarity set by the variant.
  input wire logic switch_on_pin,
  // Switch gate enable, high to conduct.
  output logic gate_en,
  // Open-drain fault indicator, low when asserted.
  input wire logic fault_n_i,
  output logic fault_n_o,
  output logic fault_n_oe
);

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  // Raw and synchronised levels between this module and the synchroniser.
  lsc_sync_if sync_bus ();

  assign sync_bus.raw = {switch_on_pin, limit_set_pin_short, overtemp, reverse_trip,
                         overcurrent};

  // Synchroniser idle levels: the switch-on bit starts at its off level, so
  // a low-active pin does not read as on for two edges after reset.
  localparam logic [lsc_pkg::SYNC_W-1:0] SYNC_IDLE =
    (VARIANT == lsc_pkg::VAR_AUTO_RETRY_LOW_ON) ?
    (lsc_pkg::SYNC_RESET | (lsc_pkg::SYNC_W'(1) << lsc_pkg::BIT_SWITCH_ON)) :
    lsc_pkg::SYNC_RESET;

  // Every asynchronous input passes two flops before use.
  lsc_sync2 #(
    .RESET_VAL(SYNC_IDLE)
  ) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .port(sync_bus.dst)
  );

  // Synchronised indications.
  logic oc_s;
  logic rev_s;
  logic otp_s;
  logic short_s;
  logic sw_on;
  // The pin readback is not needed for control; it only documents the wire.
  logic unused_fault_in;

  assign oc_s = sync_bus.sync[lsc_pkg::BIT_OVERCURRENT];
  assign rev_s = sync_bus.sync[lsc_pkg::BIT_REVERSE];
  assign otp_s = sync_bus.sync[lsc_pkg::BIT_OVERTEMP];
  assign short_s = sync_bus.sync[lsc_pkg::BIT_SET_SHORT];
  assign unused_fault_in = fault_n_i;

  // The one low-active variant turns the switch on with a low pin.
  assign sw_on = (VARIANT == lsc_pkg::VAR_AUTO_RETRY_LOW_ON) ?
                 ~sync_bus.sync[lsc_pkg::BIT_SWITCH_ON] :
                 sync_bus.sync[lsc_pkg::BIT_SWITCH_ON];

  // ----------------------------------------------------------------
  // Interval timing
  // ----------------------------------------------------------------
  // Terminal counts, cast once to the counter width.
  localparam logic [lsc_pkg::CNT_W-1:0] BLANK_LAST = lsc_pkg::CNT_W'(BLANK_CYCLES - 1);
  localparam logic [lsc_pkg::CNT_W-1:0] RETRY_LAST = lsc_pkg::CNT_W'(RETRY_CYCLES - 1);

  // Current sequencing state and its next value.
  lsc_pkg::lsc_state_t state;
  lsc_pkg::lsc_state_t next_state;
  // One counter serves both intervals, as one oscillator would.
  logic [lsc_pkg::CNT_W-1:0] cnt;
  // Blanking or retry interval has run out this cycle.
  logic blank_done;
  logic retry_done;

  assign blank_done = (cnt == BLANK_LAST);
  assign retry_done = (cnt == RETRY_LAST);

  // ----------------------------------------------------------------
  // Fault sequencing
  // ----------------------------------------------------------------
  // Next state; a switch-off command always returns to idle, which is also
  // the only way out of the latched state short of a reset.
  always_comb
  begin
    next_state = state;
    unique case (state)
      lsc_pkg::ST_IDLE:
      begin
        if (sw_on && oc_s)
          next_state = lsc_pkg::ST_BLANK;
      end
      lsc_pkg::ST_BLANK, lsc_pkg::ST_REBLANK:
      begin
        if (!sw_on || !oc_s)
          next_state = lsc_pkg::ST_IDLE;
        else if (blank_done)
        begin
          // Overcurrent lasted the full blanking interval.
          unique case (VARIANT)
            lsc_pkg::VAR_LATCH_OFF: next_state = lsc_pkg::ST_LATCHED;
            lsc_pkg::VAR_CONTINUOUS: next_state = lsc_pkg::ST_LIMIT;
            default: next_state = lsc_pkg::ST_RETRY;
          endcase
        end
      end
      lsc_pkg::ST_RETRY:
      begin
        if (!sw_on)
          next_state = lsc_pkg::ST_IDLE;
        else if (retry_done)
          next_state = lsc_pkg::ST_REBLANK;
      end
      lsc_pkg::ST_LATCHED:
      begin
        if (!sw_on)
          next_state = lsc_pkg::ST_IDLE;
      end
      lsc_pkg::ST_LIMIT:
      begin
        if (!sw_on || !oc_s)
          next_state = lsc_pkg::ST_IDLE;
      end
      default: next_state = lsc_pkg::ST_IDLE;
    endcase
  end

  // State register; reset stands for a power cycle and clears any latch.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      state <= lsc_pkg::ST_IDLE;
    else if (clk_en)
      state <= next_state;
  end

  // Interval counter; restarts on every state change so each interval
  // is measured from its own start.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      cnt <= '0;
    else if (clk_en)
    begin
      if (next_state != state)
        cnt <= '0;
      else if (state inside {lsc_pkg::ST_BLANK, lsc_pkg::ST_REBLANK, lsc_pkg::ST_RETRY})
        cnt <= cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Next gate and fault values, from the state and the instant faults.
  logic next_gate;
  logic next_fault;

  // Reverse current, heat and a grounded limit pin act without blanking.
  always_comb
  begin
    next_gate = sw_on && !rev_s && !otp_s && !short_s &&
                !(state inside {lsc_pkg::ST_RETRY, lsc_pkg::ST_LATCHED});
    next_fault = rev_s || otp_s || short_s ||
                 (state inside {lsc_pkg::ST_REBLANK, lsc_pkg::ST_RETRY,
                                lsc_pkg::ST_LATCHED, lsc_pkg::ST_LIMIT});
  end

  // Registered outputs keep glitches off the gate and the pin.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gate_en <= 1'b0;
      fault_n_oe <= 1'b0;
    end
    else if (clk_en)
    begin
      gate_en <= next_gate;
      fault_n_oe <= next_fault;
    end
  end

  // Open drain: only ever pulls low.
  assign fault_n_o = 1'b0;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Length of the current retry phase, counted apart from the interval
  // counter, so the ratio check does not lean on the count it guards.
  logic [lsc_pkg::CNT_W-1:0] retry_len;

  // Cleared outside the retry phase, one step per enabled edge inside it.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      retry_len <= '0;
    else if (clk_en)
    begin
      if (state != lsc_pkg::ST_RETRY)
        retry_len <= '0;
      else
        retry_len <= retry_len + 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn || !clk_en);

  a_blank_clear: assert property (
    (state == lsc_pkg::ST_BLANK) && !oc_s |=> state == lsc_pkg::ST_IDLE)
    else $error("Blanking did not clear when overcurrent went away.");
  a_flag_after_blank: assert property (
    (state == lsc_pkg::ST_BLANK) && sw_on && oc_s && blank_done && clk_en
    |=> ##1 fault_n_oe)
    else $error("Fault not asserted after full blanking.");
  a_retry_off_end: assert property (
    (state == lsc_pkg::ST_RETRY) && sw_on && retry_done
    |=> (state == lsc_pkg::ST_REBLANK)
    ##1 (gate_en || !$past(sw_on) || $past(rev_s || otp_s || short_s)))
    else $error("Switch not re-enabled at end of retry.");
  a_retry_gate_low: assert property (
    (state == lsc_pkg::ST_RETRY) |=> !gate_en)
    else $error("Switch on during retry interval.");
  a_cycle_flag_low: assert property (
    (state inside {lsc_pkg::ST_REBLANK, lsc_pkg::ST_RETRY}) |=> fault_n_oe)
    else $error("Fault released during auto-retry cycling.");
  a_latch_hold: assert property (
    (state == lsc_pkg::ST_LATCHED) && sw_on |=> (state == lsc_pkg::ST_LATCHED) && !gate_en)
    else $error("Latched fault left without a switch-on toggle.");
  a_latch_clear: assert property (
    (state == lsc_pkg::ST_LATCHED) && !sw_on |=> state == lsc_pkg::ST_IDLE)
    else $error("Latched fault not cleared by switch-off.");
  a_cont_conduct: assert property (
    (state == lsc_pkg::ST_LIMIT) && sw_on && !rev_s && !otp_s && !short_s
    |=> gate_en && fault_n_oe)
    else $error("Continuous mode did not conduct with fault asserted.");
  a_instant_fault: assert property (
    (rev_s || otp_s || short_s) |=> !gate_en && fault_n_oe)
    else $error("Instant fault did not turn switch off and flag.");
  a_retry_ratio: assert property (
    (state == lsc_pkg::ST_RETRY) && (next_state == lsc_pkg::ST_REBLANK)
    |-> retry_len == lsc_pkg::CNT_W'(BLANK_CYCLES * lsc_pkg::RETRY_RATIO - 1))
    else $error("Retry interval not thirty-two blanking intervals.");

  c_retry_cycle: cover property (
    (state == lsc_pkg::ST_RETRY) ##1 (state == lsc_pkg::ST_REBLANK));
  c_latch_toggle: cover property (
    (state == lsc_pkg::ST_LATCHED) ##1 (state == lsc_pkg::ST_IDLE));
  c_limit_clear: cover property (
    (state == lsc_pkg::ST_LIMIT) ##1 (state == lsc_pkg::ST_IDLE));
  c_reverse_trip: cover property (rev_s && sw_on);

endmodule

`default_nettype wire

// file: lsc_host_model.sv
/*
  Host side model: drives the switch-on pin and watches the fault pin.
  Assumes an external pull-up on the open-drain fault pin.
*/
`timescale 1ns/10ps
`default_nettype none

module lsc_host_model #(
  // High for the variant whose switch-on pin is active low.
  parameter bit LOW_ON = 1'b0
) (
  // Host request, high to turn the switch on.
  input wire logic want_on,
  output logic switch_on_pin,
  // Open-drain fault pin as seen by the host.
  input wire logic fault_n_o,
  input wire logic fault_n_oe,
  output logic fault_pin,
  output logic flag_seen
);
  // ----------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------
  // The host must match the fitted polarity or the switch turns on when the host wants it off.
  assign switch_on_pin = want_on ^ LOW_ON;
  // A released pin floats up to the pull-up level.
  assign fault_pin = fault_n_oe ? fault_n_o : 1'b1;
  // Case equality keeps an unknown pin from reading as a fault.
  assign flag_seen = (fault_pin === 1'b0);
endmodule

`default_nettype wire

// file: lsc_fault_ctrl_tb.sv
/*
  Self-checking bench: all four variants run side by side on one stimulus.
  Assumes lsc_pkg, the design files and lsc_host_model.
*/
`timescale 1ns/10ps
`default_nettype none

module lsc_fault_ctrl_tb;
  // ----------------------------------------------------------------
  // Stimulus and observed vectors (bit 0 auto, 1 low-on, 2 latch, 3 cont)
  // ----------------------------------------------------------------
  // Short blanking keeps the retry phase at 640 cycles.
  localparam int BLANK = 20;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  logic want_on = 1'b0;
  logic oc = 1'b0;
  // Instant fault causes: reverse, heat, grounded limit pin.
  logic [2:0] inst = 3'h0;
  wire logic [3:0] sw_pin, gate_v, fo, foe, fpin, flag_v;
  int miscompares = 0;
  int checks = 0;

  always #5 ref_clk = ~ref_clk;

  for (genvar v = 0; v < 4; v++)
  begin : g_var
    lsc_fault_ctrl #(.VARIANT(lsc_pkg::lsc_variant_t'(v)), .BLANK_CYCLES(BLANK)) i_lsc_fault_ctrl (
      .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .overcurrent(oc),
      .reverse_trip(inst[0]), .overtemp(inst[1]), .limit_set_pin_short(inst[2]),
      .switch_on_pin(sw_pin[v]), .gate_en(gate_v[v]), .fault_n_i(fpin[v]),
      .fault_n_o(fo[v]), .fault_n_oe(foe[v]));
    lsc_host_model #(.LOW_ON(v == 1)) i_lsc_host_model (
      .want_on(want_on), .switch_on_pin(sw_pin[v]), .fault_n_o(fo[v]),
      .fault_n_oe(foe[v]), .fault_pin(fpin[v]), .flag_seen(flag_v[v]));
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Inputs move at falling edges only, away from the sampling edge.
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic test_done;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_onoff;
    want_on = 1'b1;
    cyc(5);
    check("gate_on", gate_v, 4'hf);
    check("flag_idle", flag_v, 4'h0);
    want_on = 1'b0;
    cyc(5);
    check("gate_off", gate_v, 4'h0);
    want_on = 1'b1;
    cyc(5);
    $display("test onoff done");
  endtask

  // Bursts shorter than blanking but longer together: a timer that
  // failed to clear would fire.
  task automatic t_glitch;
    logic [3:0] seen;
    seen = 4'h0;
    for (int i = 0; i < 51; i++)
    begin
      oc = (i % 17) < 15;
      cyc(1);
      seen = seen | flag_v;
    end
    oc = 1'b0;
    cyc(5);
    check("glitch_flag", seen, 4'h0);
    check("glitch_gate", gate_v, 4'hf);
    $display("test glitch done");
  endtask

  task automatic t_overload;
    int k;
    oc = 1'b1;
    cyc(BLANK);
    check("blank_early", flag_v, 4'h0);
    k = 0;
    while (flag_v !== 4'hf && k < 10)
    begin
      cyc(1);
      k++;
    end
    if (k == 10)
    begin
      check("blank_expire", flag_v, 4'hf);
      test_done();
    end
    check("expire_gate", gate_v, 4'h8);
    cyc(628);
    check("retry_gate", gate_v, 4'h8);
    check("retry_flag", flag_v, 4'hf);
    cyc(15);
    check("reblank_gate", gate_v, 4'hb);
    check("reblank_flag", flag_v, 4'hf);
    oc = 1'b0;
    cyc(5);
    check("clear_gate", gate_v, 4'hb);
    check("clear_flag", flag_v, 4'h4);
    $display("test overload done");
  endtask

  task automatic t_latch;
    cyc(50);
    check("latch_hold", {flag_v[2], gate_v[2]}, 2'h2);
    want_on = 1'b0;
    cyc(5);
    want_on = 1'b1;
    cyc(5);
    check("unlatch_gate", gate_v, 4'hf);
    check("unlatch_flag", flag_v, 4'h0);
    $display("test latch done");
  endtask

  // Instant causes act within three edges, with no blanking wait.
  task automatic t_instant;
    for (int j = 0; j < 3; j++)
    begin
      inst = 3'h1 << j;
      cyc(4);
      check("inst_gate", gate_v, 4'h0);
      check("inst_flag", flag_v, 4'hf);
      inst = 3'h0;
      cyc(4);
      check("inst_back", gate_v, 4'hf);
      check("inst_clear", flag_v, 4'h0);
    end
    $display("test instant done");
  endtask

  // Clock enable low freezes everything, synchronisers included.
  task automatic t_freeze;
    clk_en = 1'b0;
    inst = 3'h2;
    cyc(6);
    check("freeze_gate", gate_v, 4'hf);
    check("freeze_flag", flag_v, 4'h0);
    clk_en = 1'b1;
    cyc(4);
    check("thaw_gate", gate_v, 4'h0);
    check("thaw_flag", flag_v, 4'hf);
    inst = 3'h0;
    cyc(4);
    $display("test freeze done");
  endtask

  // A power cycle, here a reset in mid-run, is the other way out of latch-off.
  task automatic t_power;
    oc = 1'b1;
    cyc(BLANK + 10);
    check("power_latched", {flag_v[2], gate_v[2]}, 2'h2);
    oc = 1'b0;
    resetn = 1'b0;
    cyc(2);
    check("power_reset", gate_v, 4'h0);
    resetn = 1'b1;
    cyc(5);
    check("power_gate", gate_v, 4'hf);
    check("power_flag", flag_v, 4'h0);
    $display("test power done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    cyc(20);
    check("reset_gate", gate_v, 4'h0);
    check("reset_flag", flag_v, 4'h0);
    resetn = 1'b1;
    check("blank_count", lsc_pkg::BLANK_CYCLES, 32'h001a_b3f0);
    check("retry_count", lsc_pkg::RETRY_CYCLES, 32'h0356_7e00);
    cyc(2);
    t_onoff();
    t_glitch();
    t_overload();
    t_latch();
    t_instant();
    t_freeze();
    t_power();
    test_done();
  end
endmodule

`default_nettype wire
